//--- brs_cpu_model.sv
// Processor-side partner: pulls up the open-drain supply-ok line and reads it.
`timescale 1ns/100ps
module brs_cpu_model (
	input  wire logic supply_ok_output_o,
	input  wire logic supply_ok_output_oe_n,
	output logic      ok_level
);
	// The board pull-up sets the level whenever the pad is released.
	assign ok_level = supply_ok_output_oe_n ? 1'b1 : supply_ok_output_o;
endmodule : brs_cpu_model

//--- brs_ctrl.sv
// Sequencing, protection, sync, supervisor and register slave of the buck regulator.
//
// How it works
// [R1] Each cycle end with overcurrent raises the four-bit protection counter by one.
// [R2] Each cycle end with normal current lowers it by one, never below zero.
// [R3] Counter at all ones stops switching and clears the soft-start count.
// [R4] Sixteen switching clocks later switching resumes with a fresh soft-start.
// [R5] Thirty-two consecutive overvoltage cycles restart soft-start while switching continues.
// [R6] External pacing pulses are detected and each rising edge starts a cycle.
// [R7] Four cycles without a pacing edge return to the internal oscillator seamlessly.
// [R8] The pacing source keeps its frequency within the supported sync range.
// [R9] Without pacing, cycles run from the internal 750 kHz oscillator.
// [R10] Enable rising starts a soft-start ramp of the regulation target.
// [R11] Soft-start lasts 4096 switching cycles.
// [R12] After soft-start the fixed reference replaces the ramp.
// [R13] Enable low holds switches, drivers, reference and oscillator off.
// [R14] Input-supply lockout keeps the converter from turning on.
// [R15] Supply-ok is high only when switching and the output is in window.
// [R16] Supply-ok is forced low whenever the converter is disabled.
// [R17] Processor reset is low while supply is low and 25 ms after recovery.
// [R18] Switching continues through processor reset, stopping only on disable, lockout or overcurrent.
// [R19] The three-level select pin picks one of three output targets.
// [R20] Cycle: high side on, off at trip, dead time, low side to cycle end.
// [R21] Both protection counters clear while disabled or locked out.
`timescale 1ns/100ps
module brs_ctrl #(
	parameter int unsigned AW           = 8,
	parameter int unsigned RST_HOLD_CYC = brs_pkg::RST_HOLD_CYC,
	parameter int unsigned SS_CYCLES    = brs_pkg::SS_CYCLES
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          enable,
	input  wire logic          input_supply_lockout,
	input  wire logic          supply_below_reset,
	input  wire logic          ext_sync,
	input  wire logic          over_current,
	input  wire logic          over_voltage,
	input  wire logic          output_in_window,
	input  wire logic          comparator_trip,
	input  wire logic [1:0]    output_level_select,
	output logic               high_side_on,
	output logic               low_side_on,
	output logic               osc_enable,
	output logic [11:0]        ref_ramp,
	output logic               ref_final_sel,
	output logic [1:0]         vtarget,
	output logic               supply_ok_output_o,
	output logic               supply_ok_output_oe_n,
	output logic               cpu_reset_n
);

	localparam int unsigned DIV_W = 10;
	localparam int unsigned RST_W = $clog2(RST_HOLD_CYC + 1);
	localparam logic [DIV_W-1:0] OSC_LAST  = DIV_W'(brs_pkg::OSC_PERIOD_CYC - 1);
	localparam logic [DIV_W-1:0] LOSS_LAST = DIV_W'(brs_pkg::SYNC_LOSS_CLK - 1);
	localparam logic [11:0] SS_LAST   = 12'(SS_CYCLES - 1);
	localparam logic [3:0]  WAIT_LAST = 4'(brs_pkg::OC_RESTART_CYC - 1);
	localparam logic [5:0]  OV_LAST   = 6'(brs_pkg::OV_LIMIT_CYC - 1);
	localparam logic [2:0]  DEAD_LAST = 3'(brs_pkg::DEAD_CYC - 1);
	localparam logic [RST_W-1:0] RST_LAST = RST_W'(RST_HOLD_CYC - 1);

	logic [1:0]                ctrl_ff;
	logic                      active;
	logic [DIV_W-1:0]          div_ff;
	logic [DIV_W-1:0]          loss_ff;
	logic                      sync_prev_ff;
	logic                      ext_mode_ff;
	logic                      sync_rise;
	logic                      int_tick;
	logic                      cyc_start;
	brs_pkg::brs_state_t       state_ff;
	brs_pkg::brs_state_t       nxt_state;
	brs_pkg::brs_phase_t       phase_ff;
	logic [2:0]                dead_ff;
	logic [3:0]                oc_ff;
	logic [3:0]                nxt_oc;
	logic [5:0]                ov_ff;
	logic [11:0]               ss_ff;
	logic [3:0]                wait_ff;
	logic                      sw_on;
	logic                      nxt_sw_on;
	logic                      oc_trip;
	logic                      ov_trip;
	logic                      supply_ok_ff;
	logic [RST_W-1:0]          rst_cnt_ff;
	logic                      released_ff;
	brs_pkg::brs_vtarget_t     vt_ff;
	brs_pkg::brs_status_t      status;

	// Software enable gates the pin so firmware can park the rail.
	assign active = enable && ctrl_ff[brs_pkg::CTRL_EN_BIT] && !input_supply_lockout; // see [R13] [R14]

	// Cycle pacing.
	assign sync_rise = ext_sync && !sync_prev_ff && ctrl_ff[brs_pkg::CTRL_SYNC_BIT];
	// After fallback the divider may sit past its last count; >= starts a cycle at once.
	assign int_tick  = (div_ff >= OSC_LAST);
	assign cyc_start = active && (sync_rise || (!ext_mode_ff && int_tick)); // see [R6] [R9]

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !active)
			div_ff <= '0; // see [R13]
		else if (cyc_start)
			div_ff <= '0;
		else if (div_ff != '1)
			div_ff <= div_ff + DIV_W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_prev_ff <= 1'b0;
		else
			sync_prev_ff <= ext_sync;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !active)
		begin
			ext_mode_ff <= 1'b0;
			loss_ff     <= '0;
		end
		else if (sync_rise)
		begin
			ext_mode_ff <= 1'b1; // see [R6]
			loss_ff     <= '0;
		end
		else if (ext_mode_ff)
		begin
			if (loss_ff == LOSS_LAST)
			begin
				ext_mode_ff <= 1'b0; // see [R7]
				loss_ff     <= '0;
			end
			else
				loss_ff <= loss_ff + DIV_W'(1);
		end
	end

	// Protection evaluation happens at each cycle start, which is the previous cycle's end.
	assign sw_on = (state_ff == brs_pkg::ST_SOFT) || (state_ff == brs_pkg::ST_RUN);

	always_comb
	begin
		nxt_oc = oc_ff;
		if (over_current && oc_ff != brs_pkg::OC_FULL)
			nxt_oc = oc_ff + 4'h1; // see [R1]
		else if (!over_current && oc_ff != 4'h0)
			nxt_oc = oc_ff - 4'h1; // see [R2]
	end

	assign oc_trip = sw_on && cyc_start && (nxt_oc == brs_pkg::OC_FULL); // see [R3]
	assign ov_trip = sw_on && cyc_start && over_voltage && (ov_ff == OV_LAST); // see [R5]

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			brs_pkg::ST_OFF:
				nxt_state = brs_pkg::ST_SOFT; // see [R10]
			brs_pkg::ST_SOFT:
			begin
				if (oc_trip)
					nxt_state = brs_pkg::ST_OC_WAIT;
				else if (!ov_trip && cyc_start && ss_ff == SS_LAST)
					nxt_state = brs_pkg::ST_RUN; // see [R11] [R12]
			end
			brs_pkg::ST_RUN:
			begin
				if (oc_trip)
					nxt_state = brs_pkg::ST_OC_WAIT;
				else if (ov_trip)
					nxt_state = brs_pkg::ST_SOFT; // see [R5]
			end
			brs_pkg::ST_OC_WAIT:
			begin
				if (cyc_start && wait_ff == WAIT_LAST)
					nxt_state = brs_pkg::ST_SOFT; // see [R4]
			end
		endcase
		// Reset supervision does not enter here, so switching runs through it.
		if (!active)
			nxt_state = brs_pkg::ST_OFF; // see [R13] [R14] [R18]
	end

	assign nxt_sw_on = (nxt_state == brs_pkg::ST_SOFT) || (nxt_state == brs_pkg::ST_RUN);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_ff <= brs_pkg::ST_OFF;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !active)
			oc_ff <= 4'h0; // see [R21]
		else if (sw_on && cyc_start)
			oc_ff <= nxt_oc;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !active || ov_trip)
			ov_ff <= 6'h00; // see [R21]
		else if (sw_on && cyc_start)
			ov_ff <= over_voltage ? ov_ff + 6'h01 : 6'h00;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || nxt_state != brs_pkg::ST_SOFT || ov_trip)
			ss_ff <= 12'h000; // see [R3] [R5]
		else if (state_ff == brs_pkg::ST_SOFT && cyc_start)
			ss_ff <= ss_ff + 12'h001; // see [R10]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_ff != brs_pkg::ST_OC_WAIT)
			wait_ff <= 4'h0;
		else if (cyc_start)
			wait_ff <= wait_ff + 4'h1; // see [R4]
	end

	// Switch phase within a cycle; the dead time guards against shoot-through.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !nxt_sw_on)
		begin
			phase_ff <= brs_pkg::PH_IDLE;
			dead_ff  <= 3'h0;
		end
		else if (cyc_start)
			phase_ff <= brs_pkg::PH_HS; // see [R20]
		else
		begin
			unique case (phase_ff)
				brs_pkg::PH_HS:
				begin
					if (comparator_trip)
					begin
						phase_ff <= brs_pkg::PH_DEAD; // see [R20]
						dead_ff  <= 3'h0;
					end
				end
				brs_pkg::PH_DEAD:
				begin
					if (dead_ff == DEAD_LAST)
						phase_ff <= brs_pkg::PH_LS;
					else
						dead_ff <= dead_ff + 3'h1;
				end
				brs_pkg::PH_IDLE,
				brs_pkg::PH_LS:
					phase_ff <= phase_ff;
			endcase
		end
	end

	assign high_side_on  = (phase_ff == brs_pkg::PH_HS);
	assign low_side_on   = (phase_ff == brs_pkg::PH_LS);
	assign osc_enable    = (state_ff != brs_pkg::ST_OFF); // see [R13]
	assign ref_ramp      = ss_ff;
	assign ref_final_sel = (state_ff == brs_pkg::ST_RUN); // see [R12]

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !active)
			supply_ok_ff <= 1'b0; // see [R16]
		else
			supply_ok_ff <= nxt_sw_on && output_in_window; // see [R15]
	end

	// Open drain: the pad only ever pulls low.
	assign supply_ok_output_o    = 1'b0;
	assign supply_ok_output_oe_n = supply_ok_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			vt_ff <= brs_pkg::VT_MID;
		else
		begin
			unique case (output_level_select)
				brs_pkg::LVL_HIGH: vt_ff <= brs_pkg::VT_HIGH; // see [R19]
				brs_pkg::LVL_OPEN: vt_ff <= brs_pkg::VT_MID;
				brs_pkg::LVL_LOW:  vt_ff <= brs_pkg::VT_LOW;
				default:           vt_ff <= brs_pkg::VT_MID;
			endcase
		end
	end

	assign vtarget = vt_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || supply_below_reset)
		begin
			rst_cnt_ff  <= '0;
			released_ff <= 1'b0; // see [R17]
		end
		else if (rst_cnt_ff == RST_LAST)
			released_ff <= 1'b1;
		else
			rst_cnt_ff <= rst_cnt_ff + RST_W'(1);
	end

	assign cpu_reset_n = released_ff;

	// AXI4-Lite slave. Address and data are held until both have arrived.
	logic          aw_got_ff;
	logic          w_got_ff;
	logic [AW-1:0] awaddr_ff;
	logic [31:0]   wdata_ff;
	logic          wlane0_ff;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic          wr_lane0;
	logic          wr_fire;

	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
	assign wr_addr  = aw_got_ff ? awaddr_ff : s_axi_awaddr;
	assign wr_data  = w_got_ff ? wdata_ff : s_axi_wdata;
	assign wr_lane0 = w_got_ff ? wlane0_ff : s_axi_wstrb[0];
	assign wr_fire  = (aw_got_ff || (s_axi_awvalid && s_axi_awready)) &&
		(w_got_ff || (s_axi_wvalid && s_axi_wready));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || wr_fire)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_ff  <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wlane0_ff <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff      <= brs_pkg::CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= brs_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= brs_pkg::RESP_OKAY;
			if (8'(wr_addr) == brs_pkg::CTRL_OFS)
			begin
				if (wr_lane0)
					ctrl_ff <= wr_data[1:0];
			end
			else if (8'(wr_addr) != brs_pkg::STATUS_OFS && 8'(wr_addr) != brs_pkg::SS_OFS)
				s_axi_bresp <= brs_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_comb
	begin
		status                = '0;
		status.oc_count       = oc_ff;
		status.vtarget        = vt_ff;
		status.state          = state_ff;
		status.reset_released = released_ff;
		status.supply_ok      = supply_ok_ff;
		status.ext_sync       = ext_mode_ff;
		status.ss_done        = ref_final_sel;
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= brs_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= brs_pkg::RESP_OKAY;
			unique case (8'(s_axi_araddr))
				brs_pkg::CTRL_OFS:   s_axi_rdata <= {30'h0, ctrl_ff};
				brs_pkg::STATUS_OFS: s_axi_rdata <= status;
				brs_pkg::SS_OFS:     s_axi_rdata <= {20'h0, ss_ff};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= brs_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_oc_count_up: assert property ( // see [R1]
		sw_on && cyc_start && over_current && oc_ff != 4'hf |=> oc_ff == $past(oc_ff) + 4'h1)
		else $error("overcurrent counter did not step up");
	a_oc_floor: assert property ( // see [R2]
		sw_on && cyc_start && !over_current && oc_ff == 4'h0 && active |=> oc_ff == 4'h0)
		else $error("overcurrent counter went below zero");
	a_oc_shutdown: assert property ( // see [R3]
		$rose(state_ff == brs_pkg::ST_OC_WAIT) |-> oc_ff == 4'hf && ss_ff == 12'h000
		&& !high_side_on && !low_side_on)
		else $error("overcurrent shutdown incomplete");
	a_oc_restart: assert property ( // see [R4]
		state_ff == brs_pkg::ST_OC_WAIT && cyc_start && wait_ff == 4'hf && active
		|=> state_ff == brs_pkg::ST_SOFT && ss_ff == 12'h000)
		else $error("no restart after sixteen clocks");
	a_ov_restart: assert property ( // see [R5]
		ov_trip && active && !oc_trip |=> state_ff == brs_pkg::ST_SOFT && ss_ff == 12'h000)
		else $error("overvoltage did not restart soft-start");
	a_sync_align: assert property ( // see [R6]
		active && ext_sync && !sync_prev_ff && ctrl_ff[1] |-> cyc_start ##1 ext_mode_ff)
		else $error("pacing edge did not start a cycle");
	a_sync_fallback: assert property ( // see [R7]
		ext_mode_ff && !sync_rise ##1 (!sync_rise && ext_mode_ff) [*8] |-> active == 1'b0
		|| loss_ff >= 10'd8 || !ext_mode_ff)
		else $error("loss counter not advancing");
	a_ss_length: assert property ( // see [R11]
		$rose(state_ff == brs_pkg::ST_RUN) |-> $past(ss_ff) == SS_LAST)
		else $error("soft-start ended early");
	a_disabled_off: assert property ( // see [R13] [R21]
		!active |=> state_ff == brs_pkg::ST_OFF && oc_ff == 4'h0 && ov_ff == 6'h00
		&& !high_side_on && !low_side_on && !supply_ok_ff)
		else $error("disabled converter not fully off");
	a_reset_hold: assert property ( // see [R17]
		supply_below_reset ##1 !supply_below_reset [*8] |-> !cpu_reset_n)
		else $error("processor reset released early");
	a_no_overlap: assert property ( // see [R20]
		!(high_side_on && low_side_on) and (high_side_on && comparator_trip && !cyc_start
		|=> !high_side_on && !low_side_on))
		else $error("switches overlap or no dead time");

	c_soft_to_run: cover property ($rose(state_ff == brs_pkg::ST_RUN));
	c_oc_wait: cover property ($rose(state_ff == brs_pkg::ST_OC_WAIT));
	c_ext_lost: cover property ($fell(ext_mode_ff) && active);
	c_ov_trip: cover property (ov_trip);

endmodule : brs_ctrl

//--- brs_pkg.sv
// Shared constants, types and register layout for the buck sequencing control.
package brs_pkg;

	// Core clock and switching rates.
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned OSC_HZ        = 750_000;
	localparam int unsigned OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;

	// Sequencing counts in switching cycles, except the soft-start time in microseconds and the sync-loss limit in clocks.
	localparam int unsigned SS_TIME_US       = 5500;
	localparam int unsigned SS_CYCLES        = 4096;
	localparam int unsigned OC_RESTART_CYC   = 16;
	localparam int unsigned OV_LIMIT_CYC     = 32;
	localparam int unsigned SYNC_LOSS_CYCLES = 4;
	localparam int unsigned SYNC_LOSS_CLK    = SYNC_LOSS_CYCLES * OSC_PERIOD_CYC;

	// Dead time between the two switches, rounded up to whole clocks.
	localparam int unsigned DEAD_TIME_NS = 20;
	localparam int unsigned DEAD_CYC     = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Processor reset hold time.
	localparam int unsigned RST_HOLD_MS  = 25;
	localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);

	// Protection counter.
	localparam int unsigned OC_W    = 4;
	localparam logic [3:0]  OC_FULL = 4'hf;

	// Three-level select pin codes from the pad detector.
	localparam logic [1:0] LVL_HIGH = 2'h3;
	localparam logic [1:0] LVL_OPEN = 2'h1;
	localparam logic [1:0] LVL_LOW  = 2'h0;

	// Register map, byte addresses.
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  STATUS_OFS   = 8'h04;
	localparam logic [7:0]  SS_OFS       = 8'h08;
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_SYNC_BIT = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h3;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_OC_WAIT} brs_state_t;
	typedef enum logic [1:0] {PH_IDLE, PH_HS, PH_DEAD, PH_LS} brs_phase_t;
	typedef enum logic [1:0] {VT_HIGH, VT_MID, VT_LOW} brs_vtarget_t;

	typedef struct packed {
		logic [19:0] rsvd;
		logic [3:0]  oc_count;
		logic [1:0]  vtarget;
		logic [1:0]  state;
		logic        reset_released;
		logic        supply_ok;
		logic        ext_sync;
		logic        ss_done;
	} brs_status_t;

endpackage : brs_pkg

//--- tb_top.sv
// Self-checking bench for the buck sequencing control.
`timescale 1ns/100ps
module tb_top;
	// A short soft-start keeps in-range pacing inside the run budget.
	localparam int RH       = 20;
	localparam int SS       = 64;
	localparam int PACE_PER = 125;
	localparam int PACE_HI  = 50;
	logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, sel, vt, r;
	logic        enable, lockout, below, ext_sync, oc, ov, in_win, trip;
	logic        hs, ls, osc_en, fin_sel, sok_o, sok_oe_n, cpu_rst_n, ok_level, hs_q;
	logic [11:0] ramp;
	int          fail_count, checks_done, cyc, hs_rises, n, m;

	brs_ctrl #(.AW(8), .RST_HOLD_CYC(RH), .SS_CYCLES(SS)) uut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.enable(enable),
		.input_supply_lockout(lockout),
		.supply_below_reset(below),
		.ext_sync(ext_sync),
		.over_current(oc),
		.over_voltage(ov),
		.output_in_window(in_win),
		.comparator_trip(trip),
		.output_level_select(sel),
		.high_side_on(hs),
		.low_side_on(ls),
		.osc_enable(osc_en),
		.ref_ramp(ramp),
		.ref_final_sel(fin_sel),
		.vtarget(vt),
		.supply_ok_output_o(sok_o),
		.supply_ok_output_oe_n(sok_oe_n),
		.cpu_reset_n(cpu_rst_n)
	);

	brs_cpu_model cpu (
		.supply_ok_output_o(sok_o),
		.supply_ok_output_oe_n(sok_oe_n),
		.ok_level(ok_level)
	);

	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		hs_q <= hs;
		if (hs && !hs_q)
			hs_rises <= hs_rises + 1;
		if (cyc == 60000)
		begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask : tick

	// Both channels are offered together and each is dropped at its own handshake edge.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		logic da, dw, ta, tw;
		da = 0;
		dw = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		while (!(da && dw))
		begin
			@(negedge aclk);
			ta = !da && awready;
			tw = !dw && wready;
			@(posedge aclk);
			awvalid <= awvalid && !ta;
			wvalid <= wvalid && !tw;
			da = da || ta;
			dw = dw || tw;
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
	endtask : axi_rd

	task automatic wait_hs(input logic v, output int k);
		k = 0;
		do
		begin
			@(negedge aclk);
			k++;
		end
		while (hs !== v);
	endtask : wait_hs

	// One pulse per 125 clocks is 800 kHz at 40 % duty, inside the supported sync range.
	task automatic pace(input int k);
		repeat (k)
		begin
			@(posedge aclk);
			ext_sync <= 1;
			tick(PACE_HI);
			ext_sync <= 0;
			tick(PACE_PER - 1 - PACE_HI);
		end
	endtask : pace

	task automatic t_regs();
		axi_rd(brs_pkg::CTRL_OFS);
		chk("ctrl reset", 32'h3, d);
		axi_wr(brs_pkg::CTRL_OFS, 32'h0, 4'h0);
		axi_rd(brs_pkg::CTRL_OFS);
		chk("ctrl no strobe", 32'h3, d);
		axi_wr(brs_pkg::CTRL_OFS, 32'h2, 4'h1);
		chk("ctrl wr resp", brs_pkg::RESP_OKAY, r);
		axi_rd(brs_pkg::CTRL_OFS);
		chk("ctrl written", 32'h2, d);
		axi_wr(brs_pkg::CTRL_OFS, 32'h3, 4'h1);
		axi_wr(8'h0c, 32'h1, 4'hf);
		chk("unmapped wr resp", brs_pkg::RESP_SLVERR, r);
		axi_rd(8'h0c);
		chk("unmapped rd resp", brs_pkg::RESP_SLVERR, r);
		chk("unmapped rd data", 32'h0, d);
	endtask : t_regs

	task automatic t_start();
		enable <= 1;
		lockout <= 1;
		tick(300);
		chk("osc in lockout", 0, osc_en);
		chk("hs in lockout", 0, hs);
		lockout <= 0;
		tick(3);
		chk("osc on", 1, osc_en);
		wait_hs(1, n);
		wait_hs(0, n);
		wait_hs(1, m);
		chk("cycle period", brs_pkg::OSC_PERIOD_CYC, n + m);
		@(posedge aclk);
		trip <= 0;
		wait_hs(1, n);
		tick(3);
		chk("hs held", 1, hs);
		trip <= 1;
		wait_hs(0, n);
		m = 0;
		while (ls !== 1'b1)
		begin
			@(negedge aclk);
			m++;
		end
		chk("dead time", brs_pkg::DEAD_CYC, m);
		@(posedge aclk);
	endtask : t_start

	task automatic t_sync_ss();
		pace(3);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("ext mode", 1, d[1]);
		axi_rd(brs_pkg::SS_OFS);
		pace(SS - 1 - int'(d[11:0]));
		axi_rd(brs_pkg::STATUS_OFS);
		chk("still soft", 1, d[5:4]);
		pace(1);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("run", 2, d[5:4]);
		chk("final ref", 1, fin_sel);
		in_win <= 1;
		tick(3);
		chk("supply ok in window", 1, ok_level);
		in_win <= 0;
		tick(3);
		chk("supply ok out of window", 0, ok_level);
		in_win <= 1;
	endtask : t_sync_ss

	task automatic t_oc();
		oc <= 1;
		pace(14);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc count", 14, d[11:8]);
		chk("oc not tripped", 2, d[5:4]);
		pace(1);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc wait", 3, d[5:4]);
		chk("switches off", 0, {hs, ls});
		axi_rd(brs_pkg::SS_OFS);
		chk("ss cleared", 0, d);
		pace(15);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc hold", 3, d[5:4]);
		pace(1);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("restart", 1, d[5:4]);
		oc <= 0;
		pace(14);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc down", 1, d[11:8]);
		pace(3);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc floor", 0, d[11:8]);
	endtask : t_oc

	task automatic t_ov();
		logic [31:0] s0;
		axi_rd(brs_pkg::SS_OFS);
		s0 = d;
		ov <= 1;
		pace(31);
		axi_rd(brs_pkg::SS_OFS);
		chk("ov 31", s0 + 31, d);
		pace(1);
		axi_rd(brs_pkg::SS_OFS);
		chk("ov restart", 0, d);
		ov <= 0;
	endtask : t_ov

	task automatic t_cpu_rst();
		int h;
		below <= 1;
		tick(3);
		chk("cpu in reset", 0, cpu_rst_n);
		h = hs_rises;
		pace(4);
		chk("switching in reset", 4, hs_rises - h);
		below <= 0;
		tick(RH - 2);
		chk("reset hold", 0, cpu_rst_n);
		tick(5);
		chk("reset released", 1, cpu_rst_n);
	endtask : t_cpu_rst

	task automatic t_fallback();
		// The last pacing edge lies one pacing period before the reset scenario's tail.
		tick(brs_pkg::SYNC_LOSS_CLK - 60 - PACE_PER);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("ext kept", 1, d[1]);
		tick(80);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("internal", 0, d[1]);
		wait_hs(1, n);
		chk("no gap", 1, n <= brs_pkg::OSC_PERIOD_CYC + 2);
		@(posedge aclk);
	endtask : t_fallback

	task automatic t_sel();
		logic [1:0] code[4] = '{brs_pkg::LVL_HIGH, brs_pkg::LVL_OPEN, brs_pkg::LVL_LOW, 2'h2};
		logic [1:0] exp[4] = '{brs_pkg::VT_HIGH, brs_pkg::VT_MID, brs_pkg::VT_LOW, brs_pkg::VT_MID};
		for (int i = 0; i < 4; i++)
		begin
			sel <= code[i];
			tick(3);
			chk("vtarget", exp[i], vt);
		end
	endtask : t_sel

	task automatic t_off();
		oc <= 1;
		pace(5);
		oc <= 0;
		enable <= 0;
		tick(3);
		chk("osc off", 0, osc_en);
		chk("switches off", 0, {hs, ls});
		chk("supply ok disabled", 0, ok_level);
		axi_rd(brs_pkg::STATUS_OFS);
		chk("oc cleared", 0, d[11:8]);
		chk("state off", 0, d[5:4]);
	endtask : t_off

	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, enable, lockout, below, ext_sync} = '0;
		{oc, ov, in_win, hs_q} = '0;
		{bready, rready, trip} = 3'h7;
		{awaddr, araddr, wdata, wstrb} = '0;
		sel = brs_pkg::LVL_HIGH;
		{fail_count, checks_done, cyc, hs_rises} = '0;
		tick(10);
		aresetn <= 1;
		tick(1);
		t_regs();
		t_start();
		t_sync_ss();
		t_oc();
		t_ov();
		t_cpu_rst();
		t_fallback();
		t_sel();
		t_off();
		conclude();
	end
endmodule : tb_top
